// *** inc/tcc_pkg.sv ***
// Purpose: Shared constants for the timer capture/compare register block
// Assumes: 32-bit APB, one 100 MHz clock, synchronous active-high reset
// Notes:   Register offsets are word indices; byte address is index times four
package tcc_pkg;

  // Clock rate and data widths
  localparam int unsigned CLK_MHZ   = 100;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned CTRL_W    = 13;
  localparam int unsigned EDGE_W    = 4;
  localparam int unsigned IRQ_W     = 3;
  localparam int unsigned PRS_W     = 3;
  localparam int unsigned PRS_CNT_W = 7;

  // Register word indices (byte address = index * 4, upper bits dropped)
  localparam logic [31:0] IDX_CCR0 = 32'hffff_f5a6;
  localparam logic [31:0] IDX_CCR1 = 32'hffff_f5a8;
  localparam logic [31:0] IDX_CNT  = 32'h0fff_f5aa;
  localparam logic [31:0] IDX_CTRL = 32'hffff_f5b0;
  localparam logic [31:0] IDX_EDGE = 32'hffff_f5b1;
  localparam logic [31:0] IDX_STAT = 32'hffff_f5b2;
  localparam logic [31:0] IDX_MASK = 32'hffff_f5b3;

  // Reset and idle values
  localparam logic [15:0]       CCR_RST  = 16'h0000;
  localparam logic [15:0]       CNT_ZERO = 16'h0000;
  localparam logic [15:0]       CNT_IDLE = 16'hffff;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [EDGE_W-1:0] EDGE_RST = 4'h0;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 3'h0;

  // Control register field positions
  localparam int unsigned CTRL_CE     = 0;
  localparam int unsigned CTRL_MD_LSB = 1;
  localparam int unsigned CTRL_CCS0   = 4;
  localparam int unsigned CTRL_CCS1   = 5;
  localparam int unsigned CTRL_OE0    = 6;
  localparam int unsigned CTRL_OE1    = 7;
  localparam int unsigned CTRL_OL0    = 8;
  localparam int unsigned CTRL_OL1    = 9;
  localparam int unsigned CTRL_PRS    = 10;

  // Status and mask bit positions
  localparam int unsigned ST_CH0 = 0;
  localparam int unsigned ST_CH1 = 1;
  localparam int unsigned ST_OVF = 2;

  // Timer mode codes
  localparam logic [2:0] MD_INTERVAL = 3'h0;
  localparam logic [2:0] MD_EVENT    = 3'h1;
  localparam logic [2:0] MD_EXT_TRIG = 3'h2;
  localparam logic [2:0] MD_ONESHOT  = 3'h3;
  localparam logic [2:0] MD_PWM      = 3'h4;
  localparam logic [2:0] MD_FREE     = 3'h5;
  localparam logic [2:0] MD_PULSE    = 3'h6;

  // Capture edge select codes
  localparam logic [1:0] EDG_NONE = 2'h0;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_FALL = 2'h2;
  localparam logic [1:0] EDG_BOTH = 2'h3;

endpackage : tcc_pkg

// *** rtl/tcc_edge_det.sv ***
// Purpose: Valid-edge detector for one capture input pin
// Assumes: Pin is synchronous to clk
// Notes:   No edge is reported until one sample has been seen after reset
`timescale 1ns/1ps
module tcc_edge_det (
  input  wire logic       clk,   // System clock
  input  wire logic       reset, // Synchronous reset, active high
  input  wire logic       pin,   // Capture input pin level
  input  wire logic [1:0] sel,   // Edge select code
  input  wire logic       arm,   // Channel is in capture function
  output logic            hit    // Valid edge seen this cycle
);
  import tcc_pkg::*;

  typedef struct packed {
    logic prev;
    logic seen;
  } tcc_edge_t;

  tcc_edge_t st_ff;
  tcc_edge_t nxt_st;
  logic      rise;
  logic      fall;

  // Remember the last sample so edges can be found
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = pin;
    nxt_st.seen = 1'b1;
  end

  // Edge qualification; no-detect code suppresses capture entirely
  always_comb begin
    rise = st_ff.seen & pin & ~st_ff.prev;
    fall = st_ff.seen & ~pin & st_ff.prev;
    case (sel)
      EDG_RISE: hit = arm & rise;
      EDG_FALL: hit = arm & fall;
      EDG_BOTH: hit = arm & (rise | fall);
      default:  hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : tcc_edge_det

// *** rtl/tcc_count_core.sv ***
// Purpose: 16-bit up-counter with count-clock prescaler
// Assumes: enable is the count-enable bit
// Notes:   Idles at all ones; first tick after enable moves it to zero
`timescale 1ns/1ps
module tcc_count_core (
  input  wire logic                       clk,       // System clock
  input  wire logic                       reset,     // Synchronous reset, active high
  input  wire logic                       enable,    // Count enable
  input  wire logic [tcc_pkg::PRS_W-1:0]  prescale,  // Count clock = clk / 2^prescale
  input  wire logic                       clr_match, // Clear to zero on this tick
  input  wire logic                       clr_now,   // Clear to zero at once
  output logic      [tcc_pkg::CNT_W-1:0]  count,     // Counter value
  output logic                            tick,      // Count clock enable pulse
  output logic                            started,   // Counter has left idle
  output logic                            overflow   // Wrapped from all ones to zero
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [PRS_CNT_W-1:0] presc;
    logic [CNT_W-1:0]     cnt;
    logic                 run;
    logic                 ovf;
  } tcc_cnt_t;

  tcc_cnt_t             st_ff;
  tcc_cnt_t             nxt_st;
  logic [PRS_CNT_W-1:0] pmask;

  // Divider mask: all ones below the selected power of two
  assign pmask = PRS_CNT_W'((8'h01 << prescale) - 8'h01);
  assign tick  = enable & ((st_ff.presc & pmask) == pmask);

  // Counting; the idle-to-zero step is not an overflow
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ovf = 1'b0;
    if (!enable) begin
      nxt_st.presc = '0;
      nxt_st.cnt   = CNT_IDLE;
      nxt_st.run   = 1'b0;
    end else begin
      nxt_st.presc = st_ff.presc + PRS_CNT_W'(1);
      if (clr_now) begin
        nxt_st.cnt = CNT_ZERO;
        nxt_st.run = 1'b1;
      end else if (tick) begin
        if (!st_ff.run) begin
          nxt_st.cnt = CNT_ZERO;
          nxt_st.run = 1'b1;
        end else if (clr_match) begin
          nxt_st.cnt = CNT_ZERO;
        end else begin
          nxt_st.cnt = st_ff.cnt + CNT_W'(1);
          nxt_st.ovf = (st_ff.cnt == CNT_IDLE);
        end
      end
    end
  end

  assign count    = st_ff.cnt;
  assign started  = st_ff.run;
  assign overflow = st_ff.ovf;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '{presc: '0, cnt: CNT_IDLE, run: 1'b0, ovf: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : tcc_count_core

// *** rtl/tcc_top.sv ***
// Purpose: Two capture/compare registers and a counter read buffer on APB
// Assumes: APB3 slave, one clock, capture pins synchronous to clk
// Notes:   Every access takes one wait state; read data is a snapshot
`timescale 1ns/1ps
module tcc_top (
  input  wire logic        clk,              // System clock, 100 MHz
  input  wire logic        reset,            // Synchronous reset, active high
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB access phase
  input  wire logic        pwrite,           // APB write
  input  wire logic [31:0] paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error for unmapped address
  input  wire logic        capture_in_pin_0, // Capture trigger, channel 0
  input  wire logic        capture_in_pin_1, // Capture trigger, channel 1
  output logic             timer_out_pin_0,  // Timer output 0
  output logic             timer_out_pin_1,  // Timer output 1
  output logic             ch0_match_irq,    // Channel 0 event pulse
  output logic             ch1_match_irq,    // Channel 1 event pulse
  output logic             irq               // Combined masked interrupt level
);
  import tcc_pkg::*;

  // All top-level state in one record
  typedef struct packed {
    logic [1:0][CNT_W-1:0] ccr;
    logic [1:0][CNT_W-1:0] bufr;
    logic [CTRL_W-1:0]     ctrl;
    logic [EDGE_W-1:0]     edge_sel;
    logic [IRQ_W-1:0]      status;
    logic [IRQ_W-1:0]      mask;
    logic                  pend;
    logic                  ce_prev;
    logic [1:0]            tog;
    logic [1:0]            pin;
    logic [1:0]            ev;
    logic                  irq;
    logic                  ack;
    logic [31:0]           rdata;
    logic                  err;
  } tcc_state_t;

  tcc_state_t        st_ff;
  tcc_state_t        nxt_st;

  // Decoded control fields
  logic              ce;
  logic [2:0]        mode;
  logic [1:0]        ccs;
  logic [1:0]        oe;
  logic [1:0]        ol;
  logic [PRS_W-1:0]  prs;
  logic              batch;
  logic              cyc_mode;
  logic              start;

  // Per-channel function and events
  logic [1:0]        is_cmp;
  logic [1:0]        is_cap;
  logic [1:0]        edge_hit;
  logic [1:0]        cap;
  logic [1:0]        match;
  logic [1:0]        cap_pins;

  // Counter interface
  logic [CNT_W-1:0]  count;
  logic              tick;
  logic              started;
  logic              overflow;
  logic              clr_match;
  logic              clr_now;
  logic              ovf_ev;

  // Bus decode
  logic              access;
  logic              take;
  logic              wr_fire;
  logic [6:0]        hit;
  logic [31:0]       rd_mux;
  logic              rd_err;
  logic [IRQ_W-1:0]  w1c;

  // Word decode against the index; the index bits above bit 29 are dropped
  function automatic logic idx_hit(input logic [31:0] addr, input logic [31:0] idx);
    idx_hit = (addr[31:2] == idx[29:0]);
  endfunction : idx_hit

  // Control fields
  assign ce       = st_ff.ctrl[CTRL_CE];
  assign mode     = st_ff.ctrl[CTRL_MD_LSB +: 3];
  assign ccs      = {st_ff.ctrl[CTRL_CCS1], st_ff.ctrl[CTRL_CCS0]};
  assign oe       = {st_ff.ctrl[CTRL_OE1], st_ff.ctrl[CTRL_OE0]};
  assign ol       = {st_ff.ctrl[CTRL_OL1], st_ff.ctrl[CTRL_OL0]};
  assign prs      = st_ff.ctrl[CTRL_PRS +: PRS_W];
  assign batch    = (mode == MD_EXT_TRIG) | (mode == MD_PWM);
  assign cyc_mode = (mode <= MD_PWM);
  assign start    = ce & ~st_ff.ce_prev;
  assign cap_pins = {capture_in_pin_1, capture_in_pin_0};

  // Function of each channel by mode and select bit (0 compare, 1 capture)
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      is_cap[i] = (mode == MD_PULSE) | ((mode == MD_FREE) & ccs[i]);
      is_cmp[i] = ~is_cap[i] & (mode <= MD_FREE);
    end
  end

  // One edge detector and one match comparator per channel
  for (genvar g = 0; g < 2; g++) begin : g_chan
    tcc_edge_det u_edge (
      .clk   (clk),
      .reset (reset),
      .pin   (cap_pins[g]),
      .sel   (st_ff.edge_sel[2*g +: 2]),
      .arm   (is_cap[g] & ce),
      .hit   (edge_hit[g])
    );
    assign cap[g]   = edge_hit[g];
    assign match[g] = ce & started & tick & is_cmp[g] & (count == st_ff.bufr[g]);
  end

  // Channel 0 match ends the cycle except in free-run; pulse width capture restarts at once
  assign clr_match = match[0] & cyc_mode;
  assign clr_now   = (mode == MD_PULSE) & (|cap);
  assign ovf_ev    = overflow & ((mode == MD_FREE) | (mode == MD_PULSE));

  tcc_count_core u_count (
    .clk       (clk),
    .reset     (reset),
    .enable    (ce),
    .prescale  (prs),
    .clr_match (clr_match),
    .clr_now   (clr_now),
    .count     (count),
    .tick      (tick),
    .started   (started),
    .overflow  (overflow)
  );

  // APB phases: first access edge snapshots, second completes
  assign access  = psel & penable;
  assign take    = access & ~st_ff.ack;
  assign wr_fire = access & st_ff.ack & pwrite;
  assign hit     = {idx_hit(paddr, IDX_MASK), idx_hit(paddr, IDX_STAT),
                    idx_hit(paddr, IDX_EDGE), idx_hit(paddr, IDX_CTRL),
                    idx_hit(paddr, IDX_CNT),  idx_hit(paddr, IDX_CCR1),
                    idx_hit(paddr, IDX_CCR0)};

  // Read mux; narrow registers sit in the low bits, upper bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (1'b1)
      hit[0]: rd_mux = {16'h0000, st_ff.ccr[0]};
      hit[1]: rd_mux = {16'h0000, st_ff.ccr[1]};
      hit[2]: rd_mux = {16'h0000, (ce ? count : CNT_ZERO)};
      hit[3]: rd_mux = {19'h0_0000, st_ff.ctrl};
      hit[4]: rd_mux = {28'h000_0000, st_ff.edge_sel};
      hit[5]: rd_mux = {29'h0000_0000, st_ff.status};
      hit[6]: rd_mux = {29'h0000_0000, st_ff.mask};
      default: rd_err = 1'b1;
    endcase
  end

  // Write-one-to-clear strobes for the status register
  assign w1c = (wr_fire & hit[5]) ? pwdata[IRQ_W-1:0] : IRQ_RST;

  // Next-state of the whole block
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.ev      = 2'b00;
    nxt_st.ce_prev = ce;

    // Bus handshake; the snapshot keeps a read stable against a capture
    if (take) begin
      nxt_st.ack   = 1'b1;
      nxt_st.rdata = pwrite ? 32'h0000_0000 : rd_mux;
      nxt_st.err   = rd_err;
    end else if (st_ff.ack) begin
      nxt_st.ack   = 1'b0;
    end

    // Register writes; a counter read buffer hit writes nothing
    if (wr_fire) begin
      for (int i = 0; i < 2; i++) begin
        if (hit[i]) begin
          nxt_st.ccr[i] = pwdata[CNT_W-1:0];
          if (!batch) begin
            nxt_st.bufr[i] = pwdata[CNT_W-1:0];
          end
        end
      end
      if (batch && hit[1]) begin
        nxt_st.pend = 1'b1;
      end
      if (hit[3]) begin
        nxt_st.ctrl = pwdata[CTRL_W-1:0];
      end
      if (hit[4]) begin
        nxt_st.edge_sel = pwdata[EDGE_W-1:0];
      end
      if (hit[6]) begin
        nxt_st.mask = pwdata[IRQ_W-1:0];
      end
    end

    // Counting start loads both buffers from the registers
    if (start) begin
      nxt_st.bufr = st_ff.ccr;
      nxt_st.pend = 1'b0;
    end else if (clr_match && st_ff.pend) begin
      nxt_st.bufr = st_ff.ccr;
      nxt_st.pend = 1'b0;
    end

    // Capture wins over a same-cycle software write of that register
    for (int i = 0; i < 2; i++) begin
      if (cap[i]) begin
        nxt_st.ccr[i] = count;
      end
    end

    // Output toggles on match; levels rest at their idle setting
    for (int i = 0; i < 2; i++) begin
      if (!ce) begin
        nxt_st.tog[i] = 1'b0;
      end else if (match[i] && oe[i]) begin
        nxt_st.tog[i] = ~st_ff.tog[i];
      end
      nxt_st.pin[i] = nxt_st.tog[i] ^ ol[i];
      nxt_st.ev[i]  = match[i] | cap[i];
    end

    // Sticky status: a new event beats a clear in the same cycle
    nxt_st.status = (st_ff.status & ~w1c) | {ovf_ev, nxt_st.ev};
    nxt_st.irq    = |(nxt_st.status & nxt_st.mask);
  end

  // State register; reset clears both capture/compare registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '{ccr: {CCR_RST, CCR_RST}, bufr: {CCR_RST, CCR_RST},
                 ctrl: CTRL_RST, edge_sel: EDGE_RST, status: IRQ_RST,
                 mask: IRQ_RST, pend: 1'b0, ce_prev: 1'b0, tog: 2'b00,
                 pin: 2'b00, ev: 2'b00, irq: 1'b0, ack: 1'b0,
                 rdata: 32'h0000_0000, err: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs; pready and pslverr are the only combinational ones
  assign pready          = access & st_ff.ack;
  assign prdata          = st_ff.rdata;
  assign pslverr         = pready & st_ff.err;
  assign timer_out_pin_0 = st_ff.pin[0];
  assign timer_out_pin_1 = st_ff.pin[1];
  assign ch0_match_irq   = st_ff.ev[0];
  assign ch1_match_irq   = st_ff.ev[1];
  assign irq             = st_ff.irq;

endmodule : tcc_top

// *** sim/tcc_assertions.sv ***
// Purpose: Port checks for the capture/compare register block
// Assumes: Master holds each APB request until pready
// Notes:   Bound to tcc_top and sees its ports only
`timescale 1ns/1ps
module tcc_checker (
  input wire logic        clk,             // System clock
  input wire logic        reset,           // Synchronous reset
  input wire logic        psel,            // APB select
  input wire logic        penable,         // APB access phase
  input wire logic        pwrite,          // APB write
  input wire logic [31:0] paddr,           // APB address
  input wire logic [31:0] prdata,          // APB read data
  input wire logic        pready,          // APB ready
  input wire logic        pslverr,         // APB error
  input wire logic        ch0_match_irq,   // Channel 0 event
  input wire logic        ch1_match_irq,   // Channel 1 event
  input wire logic        irq,             // Interrupt level
  input wire logic        timer_out_pin_0, // Timer output 0
  input wire logic        timer_out_pin_1  // Timer output 1
);
  import tcc_pkg::*;
  logic wr_done; // A write completes at this edge
  logic mapped;  // Address hits a register
  // Decode kept here so a wrong decode in the design shows up as a bad error flag
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped  = paddr[31:2] inside {IDX_CCR0[29:0], IDX_CCR1[29:0], IDX_CNT[29:0],
                   IDX_CTRL[29:0], IDX_EDGE[29:0], IDX_STAT[29:0], IDX_MASK[29:0]};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Handshake: exactly one wait state, ready for one cycle
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  access_wait_a: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("access not answered after one wait state");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  // Error and read data shape
  err_decode_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  rdata_upper_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  rdata_hold_a: assert property (!(psel && penable && !pready) |=> $stable(prdata))
    else $error("read data moved outside a snapshot");
  // Interrupt only drops after software touched status or mask
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("irq dropped without a write");
  reset_quiet_a: assert property (disable iff (1'b0) reset |=> !irq && !ch0_match_irq &&
    !ch1_match_irq && !timer_out_pin_0 && !timer_out_pin_1 && prdata == 32'h0000_0000)
    else $error("outputs not quiet after reset");
  ev0_c: cover property (ch0_match_irq);
  ev1_c: cover property (ch1_match_irq);
  err_c: cover property (pready && pslverr);
  irq_c: cover property ($rose(irq));
endmodule : tcc_checker

bind tcc_top tcc_checker u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ch0_match_irq(ch0_match_irq), .ch1_match_irq(ch1_match_irq), .irq(irq),
  .timer_out_pin_0(timer_out_pin_0), .timer_out_pin_1(timer_out_pin_1));

// *** sim/tcc_pin_model.sv ***
// Purpose: Capture trigger pins driven from the far side
// Assumes: Pins are synchronous to clk
// Notes:   Pins only move at a clock edge, on request
`timescale 1ns/1ps
module tcc_pin_model (
  input  wire logic       clk,   // System clock
  input  wire logic       reset, // Synchronous reset, active high
  input  wire logic [1:0] flip,  // Invert these pins at this edge
  output logic            pin_0, // Capture input 0
  output logic            pin_1  // Capture input 1
);
  // Edge-aligned moves keep the pins clean for the design's edge detector
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_0 <= 1'b0;
      pin_1 <= 1'b0;
    end else begin
      pin_0 <= pin_0 ^ flip[0];
      pin_1 <= pin_1 ^ flip[1];
    end
  end
endmodule : tcc_pin_model

// *** sim/tcc_top_tb.sv ***
// Purpose: Self-checking bench for the capture/compare register block
// Assumes: Prescale 0, so the counter ticks every clock
// Notes:   Random values come from a fixed-seed xorshift
`timescale 1ns/1ps
module tcc_top_tb;
  import tcc_pkg::*;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic        pin0, pin1, out0, out1, ev0, ev1, irq;
  logic [1:0]  flip;
  logic [31:0] paddr, pwdata, prdata, rd, seed, n, m, a, b;
  int          n_errors, comparisons, cycles, t0, t1;

  tcc_top u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_in_pin_0(pin0), .capture_in_pin_1(pin1), .timer_out_pin_0(out0),
    .timer_out_pin_1(out1), .ch0_match_irq(ev0), .ch1_match_irq(ev1), .irq(irq));
  tcc_pin_model u_pins (.clk(clk), .reset(reset), .flip(flip), .pin_0(pin0), .pin_1(pin1));

  // Clock and hang guard; the tests need a few hundred cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; all accesses run with the main clock live
  task automatic apb(input logic w, input logic [31:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx[29:0], 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_ev(input logic ch, output int t);
    do @(posedge clk); while ((ch ? ev1 : ev0) !== 1'b1);
    t = cycles;
  endtask : wait_ev

  // Cycle-register clear makes the match period the compare value plus one
  task automatic period_chk(input logic ch, input logic [31:0] d);
    wait_ev(ch, t0);
    wait_ev(ch, t1);
    chk(t1 - t0, d[15:0] + 32'h0000_0001, "match period");
  endtask : period_chk

  task automatic toggle(input logic [1:0] which);
    @(posedge clk);
    flip <= which;
    @(posedge clk);
    flip <= 2'b00;
  endtask : toggle

  // Captured value must lie between counter reads around the pin edge
  task automatic cap_chk(input logic [31:0] idx);
    apb(0, IDX_CNT, 0);
    a = rd;
    toggle(2'b11);
    apb(0, idx, 0);
    m = rd;
    apb(0, IDX_CNT, 0);
    chk(a <= m && m <= rd, 1, "capture window");
  endtask : cap_chk

  initial begin
    seed = 32'd38058;
    {psel, penable, pwrite, err, flip} = '0;
    {paddr, pwdata} = '0;
    {n_errors, comparisons, cycles} = '0;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Reset values, unmapped access, random data round trips
    apb(0, IDX_CCR0, 0);
    chk(rd, 0, "ccr0 reset");
    apb(0, IDX_CCR1, 0);
    chk(rd, 0, "ccr1 reset");
    apb(0, IDX_CNT, 0);
    chk(rd, 0, "cnt reset");
    apb(0, 32'h0000_0001, 0);
    chk(err, 1, "unmapped error");
    for (int i = 0; i < 8; i++) begin
      n = rnd();
      apb(1, i[0] ? IDX_CCR1 : IDX_CCR0, n);
      apb(0, i[0] ? IDX_CCR1 : IDX_CCR0, 0);
      chk(rd, {16'h0000, n[15:0]}, "ccr round trip");
    end
    $display("test registers done");
    // Interval mode with both outputs enabled
    n = 32'd3 + (rnd() % 8);
    m = n + 32'd4;
    apb(1, IDX_CCR0, n);
    apb(1, IDX_CCR1, n - 32'd2);
    apb(1, IDX_CTRL, 32'h0000_00c1);
    period_chk(0, n);
    period_chk(1, n);
    wait_ev(0, t0);
    repeat (2) @(posedge clk);
    a = out0;
    b = out1;
    wait_ev(0, t0);
    repeat (2) @(posedge clk);
    chk(out0, !a[0], "output toggle");
    chk(out1, !b[0], "output toggle");
    apb(1, IDX_CCR0, m);
    period_chk(0, m);
    apb(0, IDX_CNT, 0);
    chk(rd <= m, 1, "live count");
    apb(1, IDX_CTRL, 0);
    apb(0, IDX_CNT, 0);
    chk(rd, 0, "stopped count");
    // Idle levels show on both outputs while counting is stopped
    apb(1, IDX_CTRL, 32'h0000_0300);
    repeat (2) @(posedge clk);
    chk(out0 & out1, 1, "idle level");
    apb(1, IDX_CNT, rnd());
    chk(err, 0, "cnt write error");
    apb(0, IDX_CNT, 0);
    chk(rd, 0, "cnt write ignored");
    $display("test interval done");
    // PWM: compare writes wait for the batch load armed by channel 1
    apb(1, IDX_CCR0, n);
    apb(1, IDX_CTRL, 32'h0000_0009);
    apb(1, IDX_CCR0, m);
    period_chk(0, n);
    apb(1, IDX_CCR1, n - 32'd1);
    // The arming write may land on a cycle end; skip one match so the load is behind us
    wait_ev(0, t0);
    period_chk(0, m);
    apb(1, IDX_CTRL, 0);
    $display("test batch done");
    // Free-run: ignored captures first, then real ones
    apb(1, IDX_CCR0, 32'h0000_1234);
    apb(1, IDX_CCR1, 32'h0000_ff00);
    apb(1, IDX_EDGE, 32'h0000_000c);
    apb(1, IDX_CTRL, 32'h0000_001b);
    toggle(2'b11);
    repeat (3) @(posedge clk);
    apb(0, IDX_CCR0, 0);
    chk(rd, 32'h0000_1234, "no edge ignored");
    apb(0, IDX_CCR1, 0);
    chk(rd, 32'h0000_ff00, "compare ignores pin");
    apb(1, IDX_CTRL, 0);
    apb(1, IDX_EDGE, 32'h0000_000f);
    apb(1, IDX_CTRL, 32'h0000_003b);
    cap_chk(IDX_CCR0);
    cap_chk(IDX_CCR1);
    apb(1, IDX_CTRL, 0);
    $display("test capture done");
    // Sticky status, mask and clear
    apb(0, IDX_STAT, 0);
    chk(rd[0], 1, "status sticky");
    apb(1, IDX_MASK, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(irq, 1, "irq unmasked");
    apb(1, IDX_MASK, 0);
    repeat (3) @(posedge clk);
    chk(irq, 0, "irq masked");
    apb(1, IDX_MASK, 32'h0000_0001);
    apb(1, IDX_STAT, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(irq, 0, "irq cleared");
    $display("test interrupt done");
    // Pulse width: capture on a rising edge also clears the counter
    // Pins are high here; bring them low while stopped so the next move is a rise
    toggle(2'b11);
    apb(1, IDX_EDGE, 32'h0000_0009);
    apb(1, IDX_CTRL, 32'h0000_000d);
    repeat (60) @(posedge clk);
    apb(0, IDX_CNT, 0);
    a = rd;
    toggle(2'b01);
    apb(0, IDX_CCR0, 0);
    b = rd;
    apb(0, IDX_CNT, 0);
    chk(b >= a, 1, "pulse capture");
    chk(rd < a, 1, "pulse clear");
    $display("test pulse done");
    close_out();
  end

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
endmodule : tcc_top_tb
